// ---- src/link_ctrl_map.svh ----
`ifndef LINK_CTRL_MAP_SVH
`define LINK_CTRL_MAP_SVH
// ------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_RESULT 8'h08
`define OFS_DATA_LO 8'h0C
`define OFS_DATA_HI 8'h10
`define OFS_PAGES 8'h14
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTRL_PWR_DOWN 0
`define CTRL_START_CAL 1
`define CTRL_START_UP 2
`define ST_BUSY 0
`define ST_CAL_DONE 1
`define ST_PAGE_REQ 2
`define ST_UP_DONE 3
`define ST_PAGE_LSB 8
// ------------------------------------------------------------
// Reset values and figures
// ------------------------------------------------------------
`define PAGES_RESET 4'h6
`define PAGE_BITS 64
`define RESULT_BITS 24
`define STROBE_NS 20000
`define SETTLE_NS 10000
`define PAGE_WRITE_NS 2000000
`define CLK_NS 20
`endif

// ---- src/link_ctrl_pkg.sv ----
package link_ctrl_pkg;
  // Sequencer states of the host side.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CAL_ENTER = 4'b0001,
    ST_CAL_LOW = 4'b0010,
    ST_CAL_HIGH = 4'b0011,
    ST_CAL_END = 4'b0100,
    ST_UP_WAIT = 4'b0101,
    ST_UP_BIT = 4'b0110,
    ST_UP_ACK = 4'b0111,
    ST_UP_GAP = 4'b1000,
    ST_UP_PAGE = 4'b1001
  } seq_state_t;
endpackage

// ---- src/link_host_ctrl.sv ----
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "link_ctrl_map.svh"

// Contract
// - Unused power pin is held low.
// - Strobe high, calibrate low requests calibration.
// - Host pulses strobe per bit; 24 then ack high.
// - Calibrate pin high ends calibration.
// - Strobe low, calibrate low requests upload; the code enters upload with strobe high.
// - Pages of eight bytes, 64 bits, serially.
// - Counters start at one; strobe low, first bit.
// - Device samples, pulses ack; host alternates strobes.
// - Next page starts with strobe low; 6 or 13.
// - Page bits go bit 63 first, bit 0 last.
// - Calibrate pin high ends setup mode.
module link_host_ctrl #(
  parameter int PAGE_WAIT_CYC = (`PAGE_WRITE_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int STROBE_CYC = (`STROBE_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int SETTLE_CYC = (`SETTLE_NS + `CLK_NS - 1) / `CLK_NS
) (
  input wire logic clk_i, // System clock, 50 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic ce_i, // Clock enable, freezes state when low.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  output logic power_control_n_o, // Power pin, high powers down.
  output logic host_strobe_n_o, // Host strobe pin.
  output logic cal_select_n_o, // Calibrate-select pin.
  output logic upload_serial_in_o, // Serial upload data pin.
  input wire logic ack_clk_n_i, // Device acknowledge clock.
  input wire logic result_serial_out_i // Device serial result.
);

  // ----------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------
  localparam int TW = 24;

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [1:0] ack_sync_q, ack_sync_d;
  logic [1:0] res_sync_q, res_sync_d;
  logic ack_n;
  logic res_bit;

  // Two flops on each pin coming from the device.
  always_comb begin
    ack_sync_d = {ack_sync_q[0], ack_clk_n_i};
    res_sync_d = {res_sync_q[0], result_serial_out_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_sync_q <= 2'h3;
      res_sync_q <= 2'h0;
    end else if (ce_i) begin
      ack_sync_q <= ack_sync_d;
      res_sync_q <= res_sync_d;
    end
  end

  assign ack_n = ack_sync_q[1];
  assign res_bit = res_sync_q[1];

  // ----------------------------------------------------------
  // Sequencer and registers
  // ----------------------------------------------------------
  link_ctrl_pkg::seq_state_t state_q, state_d;
  logic [TW-1:0] timer_q, timer_d;
  logic [6:0] bit_q, bit_d;
  logic [3:0] page_q, page_d;
  logic [3:0] pages_q, pages_d;
  logic [63:0] shift_q, shift_d;
  logic [31:0] data_lo_q, data_lo_d;
  logic [23:0] result_q, result_d;
  logic pwr_q, pwr_d;
  logic strobe_q, strobe_d;
  logic cal_q, cal_d;
  logic dout_q, dout_d;
  logic cal_done_q, cal_done_d;
  logic up_done_q, up_done_d;
  logic page_full_q, page_full_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic wr, rd_sel;

  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
  assign rd_sel = wb_cyc_i & wb_stb_i & ~ack_q;

  // Next-state logic of the handshake sequencer and the bus slave.
  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    bit_d = bit_q;
    page_d = page_q;
    pages_d = pages_q;
    shift_d = shift_q;
    data_lo_d = data_lo_q;
    result_d = result_q;
    pwr_d = pwr_q;
    strobe_d = strobe_q;
    cal_d = cal_q;
    dout_d = dout_q;
    cal_done_d = cal_done_q;
    up_done_d = up_done_q;
    page_full_d = page_full_q;
    ack_d = rd_sel;
    rdat_d = 32'h0000_0000;
    if (timer_q != '0) begin
      timer_d = timer_q - 1'b1;
    end
    // Register writes; a page handed in while idle is refused.
    if (wr) begin
      case (wb_adr_i)
        `OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            pwr_d = wb_dat_i[`CTRL_PWR_DOWN];
          end
        end
        `OFS_DATA_LO: begin
          data_lo_d = wb_dat_i;
        end
        `OFS_DATA_HI: begin
          if (state_q == link_ctrl_pkg::ST_UP_WAIT) begin
            shift_d = {wb_dat_i, data_lo_q};
            page_full_d = 1'b1;
          end
        end
        `OFS_PAGES: begin
          if (wb_sel_i[0] && state_q == link_ctrl_pkg::ST_IDLE) begin
            pages_d = wb_dat_i[3:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Read data, unmapped addresses read as zero.
    case (wb_adr_i)
      `OFS_CTRL: rdat_d = {31'h0000_0000, pwr_q};
      `OFS_STATUS: rdat_d = {20'h0_0000, page_q, 4'h0, up_done_q,
        state_q == link_ctrl_pkg::ST_UP_WAIT && !page_full_q,
        cal_done_q, state_q != link_ctrl_pkg::ST_IDLE};
      `OFS_RESULT: rdat_d = {8'h00, result_q};
      `OFS_DATA_LO: rdat_d = data_lo_q;
      `OFS_PAGES: rdat_d = {28'h000_0000, pages_q};
      default: rdat_d = 32'h0000_0000;
    endcase
    case (state_q)
      link_ctrl_pkg::ST_IDLE: begin
        strobe_d = 1'b1;
        cal_d = 1'b1;
        if (wr && wb_adr_i == `OFS_CTRL && wb_sel_i[0] &&
            !wb_dat_i[`CTRL_PWR_DOWN] && !pwr_q) begin
          if (wb_dat_i[`CTRL_START_CAL]) begin
            cal_d = 1'b0;
            cal_done_d = 1'b0;
            bit_d = 7'h00;
            state_d = link_ctrl_pkg::ST_CAL_ENTER;
          end else if (wb_dat_i[`CTRL_START_UP]) begin
            cal_d = 1'b0;
            strobe_d = 1'b1;
            up_done_d = 1'b0;
            page_d = 4'h1;
            page_full_d = 1'b0;
            state_d = link_ctrl_pkg::ST_UP_WAIT;
          end
        end
      end
      // Device drops the ack clock with the first bit ready.
      link_ctrl_pkg::ST_CAL_ENTER: begin
        if (!ack_n) begin
          timer_d = TW'(SETTLE_CYC);
          state_d = link_ctrl_pkg::ST_CAL_LOW;
        end
      end
      // Take the presented bit, then pulse the strobe low.
      link_ctrl_pkg::ST_CAL_LOW: begin
        if (timer_q == '0 && strobe_q) begin
          result_d = {result_q[22:0], res_bit};
          strobe_d = 1'b0;
          timer_d = TW'(STROBE_CYC);
        end else if (timer_q == '0) begin
          strobe_d = 1'b1;
          bit_d = bit_q + 7'h01;
          timer_d = TW'(SETTLE_CYC);
          state_d = link_ctrl_pkg::ST_CAL_HIGH;
        end
      end
      link_ctrl_pkg::ST_CAL_HIGH: begin
        if (timer_q == '0) begin
          if (bit_q == 7'(`RESULT_BITS)) begin
            state_d = link_ctrl_pkg::ST_CAL_END;
          end else begin
            state_d = link_ctrl_pkg::ST_CAL_LOW;
          end
        end
      end
      // After the last pulse the ack clock returns high.
      link_ctrl_pkg::ST_CAL_END: begin
        if (ack_n) begin
          cal_d = 1'b1;
          cal_done_d = 1'b1;
          state_d = link_ctrl_pkg::ST_IDLE;
        end
      end
      // Wait for software to hand in a 64-bit page.
      link_ctrl_pkg::ST_UP_WAIT: begin
        if (page_full_q) begin
          bit_d = 7'h01;
          dout_d = shift_q[63];
          strobe_d = 1'b0;
          state_d = link_ctrl_pkg::ST_UP_BIT;
        end
      end
      // Bit presented with strobe low; wait for the ack pulse.
      link_ctrl_pkg::ST_UP_BIT: begin
        if (!ack_n) begin
          state_d = link_ctrl_pkg::ST_UP_ACK;
        end
      end
      link_ctrl_pkg::ST_UP_ACK: begin
        if (ack_n) begin
          strobe_d = 1'b1;
          timer_d = TW'(STROBE_CYC);
          state_d = link_ctrl_pkg::ST_UP_GAP;
        end
      end
      // Strobe high between bits; the last one ends the page.
      link_ctrl_pkg::ST_UP_GAP: begin
        if (timer_q == '0) begin
          if (bit_q == 7'(`PAGE_BITS)) begin
            page_full_d = 1'b0;
            timer_d = TW'(PAGE_WAIT_CYC);
            state_d = link_ctrl_pkg::ST_UP_PAGE;
          end else begin
            shift_d = {shift_q[62:0], 1'b0};
            dout_d = shift_q[62];
            bit_d = bit_q + 7'h01;
            strobe_d = 1'b0;
            state_d = link_ctrl_pkg::ST_UP_BIT;
          end
        end
      end
      // Let the EEPROM page write finish before moving on.
      link_ctrl_pkg::ST_UP_PAGE: begin
        if (timer_q == '0) begin
          if (page_q == pages_q) begin
            cal_d = 1'b1;
            up_done_d = 1'b1;
            state_d = link_ctrl_pkg::ST_IDLE;
          end else begin
            page_d = page_q + 4'h1;
            state_d = link_ctrl_pkg::ST_UP_WAIT;
          end
        end
      end
      default: begin
        state_d = link_ctrl_pkg::ST_IDLE;
      end
    endcase
  end

  // State registers; the power pin resets low so the device runs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= link_ctrl_pkg::ST_IDLE;
      timer_q <= '0;
      bit_q <= 7'h00;
      page_q <= 4'h0;
      pages_q <= `PAGES_RESET;
      shift_q <= 64'h0000_0000_0000_0000;
      data_lo_q <= 32'h0000_0000;
      result_q <= 24'h00_0000;
      pwr_q <= 1'b0;
      strobe_q <= 1'b1;
      cal_q <= 1'b1;
      dout_q <= 1'b0;
      cal_done_q <= 1'b0;
      up_done_q <= 1'b0;
      page_full_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      state_q <= state_d;
      timer_q <= timer_d;
      bit_q <= bit_d;
      page_q <= page_d;
      pages_q <= pages_d;
      shift_q <= shift_d;
      data_lo_q <= data_lo_d;
      result_q <= result_d;
      pwr_q <= pwr_d;
      strobe_q <= strobe_d;
      cal_q <= cal_d;
      dout_q <= dout_d;
      cal_done_q <= cal_done_d;
      up_done_q <= up_done_d;
      page_full_q <= page_full_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  // All pins and bus data come straight from flops.
  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign power_control_n_o = pwr_q;
  assign host_strobe_n_o = strobe_q;
  assign cal_select_n_o = cal_q;
  assign upload_serial_in_o = dout_q;

endmodule // link_host_ctrl

// ---- verif/link_host_ctrl_asserts.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Bus and pin checks
// ----------------------------------------
module link_host_ctrl_asserts (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic ce_i, // Enable.
  input wire logic wb_cyc_i, // Cycle.
  input wire logic wb_stb_i, // Strobe.
  input wire logic wb_ack_o, // Ack.
  input wire logic power_control_n_o, // Power pin.
  input wire logic host_strobe_n_o, // Strobe pin.
  input wire logic cal_select_n_o, // Mode pin.
  input wire logic upload_serial_in_o, // Data pin.
  input wire logic ack_clk_n_i // Device ack.
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // A taken bus request and the start of a strobe pulse.
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_strobe_start;
    $fell(host_strobe_n_o);
  endsequence
  a_ack_follows_req: assert property (s_bus_req |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_entry_powered: assert property (
    $fell(cal_select_n_o) |-> !power_control_n_o)
    else $error("mode entered while powered down");
  a_entry_strobe_high: assert property (
    $fell(cal_select_n_o) |-> host_strobe_n_o)
    else $error("mode entered with strobe low");
  a_strobe_in_mode: assert property (
    !host_strobe_n_o |-> !cal_select_n_o)
    else $error("strobe low outside a mode");
  a_strobe_low_min: assert property (
    s_strobe_start |-> !host_strobe_n_o [*4])
    else $error("strobe pulse too short");
  a_end_after_ack: assert property (
    $rose(cal_select_n_o) |-> ack_clk_n_i && host_strobe_n_o)
    else $error("mode ended before device ack high");
  a_data_held: assert property (
    !host_strobe_n_o && !$past(host_strobe_n_o)
    |-> $stable(upload_serial_in_o))
    else $error("upload data changed under strobe");
endmodule // link_host_ctrl_asserts

bind link_host_ctrl link_host_ctrl_asserts u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .power_control_n_o(power_control_n_o),
  .host_strobe_n_o(host_strobe_n_o), .cal_select_n_o(cal_select_n_o),
  .upload_serial_in_o(upload_serial_in_o), .ack_clk_n_i(ack_clk_n_i));

// ---- verif/link_dev_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Device side of the link
// ----------------------------------------
module link_dev_model #(
  parameter logic [23:0] WORD = 24'h00_0000
) (
  input wire logic power_control_n_i, // Power pin.
  input wire logic host_strobe_n_i, // Strobe pin.
  input wire logic cal_select_n_i, // Mode pin.
  input wire logic upload_serial_in_i, // Data pin.
  input wire logic upload_mode_i, // Next mode is upload.
  output logic ack_clk_n_o = 1'b1, // Ack pin.
  output logic result_serial_out_o = 1'b0, // Result pin.
  output logic [63:0] page_o = 64'h0, // Last bits taken.
  output int bits_o = 0 // Bits taken.
);
  logic dclk = 1'b0;
  // Own oscillator, 160 ns period; its rising edges fall on falling edges of the system clock.
  always #80 dclk = ~dclk;
  // Serves one mode request while powered, then waits for its end.
  always begin
    @(posedge dclk iff (cal_select_n_i === 1'b0 &&
      power_control_n_i === 1'b0));
    if (upload_mode_i === 1'b0) begin
      for (int i = 23; i >= 0; i--) begin
        ack_clk_n_o <= 1'b0;
        result_serial_out_o <= WORD[i];
        @(posedge dclk iff host_strobe_n_i === 1'b0);
        @(posedge dclk iff host_strobe_n_i === 1'b1);
      end
      ack_clk_n_o <= 1'b1;
      result_serial_out_o <= ~WORD[0];
    end else begin
      bits_o <= 0;
      while (cal_select_n_i === 1'b0) begin
        @(posedge dclk);
        if (host_strobe_n_i === 1'b0) begin
          page_o <= {page_o[62:0], upload_serial_in_i};
          bits_o <= bits_o + 1;
          ack_clk_n_o <= 1'b0;
          repeat (3) @(posedge dclk);
          ack_clk_n_o <= 1'b1;
          @(posedge dclk iff host_strobe_n_i === 1'b1);
        end
      end
    end
    @(posedge dclk iff cal_select_n_i === 1'b1);
  end
endmodule // link_dev_model

// ---- verif/setup_calibration_link_ctrl_test.sv ----
`timescale 1ns/10ps
`include "link_ctrl_map.svh"
// ----------------------------------------
// Host controller bench
// ----------------------------------------
module setup_calibration_link_ctrl_test;
  localparam logic [23:0] WORD = 24'h80_2469;
  localparam logic [63:0] PAGE = 64'h0123_4567_89ab_cdef;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic upload_mode = 1'b0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, power_control_n_o, host_strobe_n_o, cal_select_n_o;
  logic upload_serial_in_o, ack_clk_n_i, result_serial_out_i;
  logic [63:0] page;
  int bits;
  int errors = 0;
  int checked = 0;
  // System clock.
  always #10 clk_i = ~clk_i;
  link_host_ctrl #(.PAGE_WAIT_CYC(20), .STROBE_CYC(40), .SETTLE_CYC(20))
    u_link_host_ctrl (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .power_control_n_o(power_control_n_o), .host_strobe_n_o(host_strobe_n_o),
    .cal_select_n_o(cal_select_n_o), .upload_serial_in_o(upload_serial_in_o),
    .ack_clk_n_i(ack_clk_n_i), .result_serial_out_i(result_serial_out_i));
  link_dev_model #(.WORD(WORD)) u_link_dev_model (
    .power_control_n_i(power_control_n_o), .host_strobe_n_i(host_strobe_n_o),
    .cal_select_n_i(cal_select_n_o), .upload_serial_in_i(upload_serial_in_o),
    .upload_mode_i(upload_mode), .ack_clk_n_o(ack_clk_n_i),
    .result_serial_out_o(result_serial_out_i), .page_o(page), .bits_o(bits));
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One classic bus cycle; read data is taken at the ack edge.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      errors++;
      end_of_test();
    end
  endtask
  // Polls the status word until the given flag is set.
  task automatic wait_st(input int b);
    int n;
    n = 0;
    do begin
      wb(1'b0, `OFS_STATUS, 32'h0000_0000);
      n++;
    end while (q[b] !== 1'b1 && n < 5000);
    if (q[b] !== 1'b1) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic t_reset();
    chk("strobe idle", 1'b1, host_strobe_n_o);
    chk("power idle", 1'b0, power_control_n_o);
    wb(1'b0, `OFS_PAGES, 32'h0000_0000);
    chk("pages", 32'h0000_0006, q);
    wb(1'b0, 8'h3c, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
  endtask
  // A request held while the clock enable is low gets no answer.
  task automatic t_freeze();
    int n;
    n = 0;
    @(posedge clk_i);
    ce_i <= 1'b0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= 1'b0;
    wb_adr_i <= `OFS_PAGES;
    repeat (4) begin
      @(posedge clk_i);
      chk("frozen ack", 1'b0, wb_ack_o);
    end
    ce_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    chk("thawed ack", 1'b1, wb_ack_o);
    chk("thawed data", 32'h0000_0006, wb_dat_o);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      end_of_test();
    end
  endtask
  // A reset in mid-run clears the flags and result and sets the page count back to 6.
  task automatic t_mid_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("reset cal pin", 1'b1, cal_select_n_o);
    chk("reset strobe", 1'b1, host_strobe_n_o);
    wb(1'b0, `OFS_RESULT, 32'h0000_0000);
    chk("reset result", 32'h0000_0000, q);
    wb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk("reset status", 32'h0000_0000, q);
    wb(1'b0, `OFS_PAGES, 32'h0000_0000);
    chk("reset pages", 32'h0000_0006, q);
  endtask
  task automatic t_power();
    wb(1'b1, `OFS_CTRL, 32'h0000_0001);
    wb(1'b1, `OFS_CTRL, 32'h0000_0003);
    wb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk("power down", 1'b1, power_control_n_o);
    chk("no mode", 1'b1, cal_select_n_o);
    wb(1'b1, `OFS_CTRL, 32'h0000_0000);
    wb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk("power up", 1'b0, power_control_n_o);
  endtask
  task automatic t_cal();
    upload_mode <= 1'b0;
    wb(1'b1, `OFS_CTRL, 32'h0000_0002);
    wait_st(`ST_CAL_DONE);
    wb(1'b0, `OFS_RESULT, 32'h0000_0000);
    chk("result", {8'h00, WORD}, q);
    chk("cal end", 1'b1, cal_select_n_o);
  endtask
  task automatic t_upload();
    upload_mode <= 1'b1;
    wb(1'b1, `OFS_PAGES, 32'h0000_0002);
    wb(1'b1, `OFS_CTRL, 32'h0000_0004);
    wait_st(`ST_PAGE_REQ);
    chk("page number", 4'h1, q[11:8]);
    chk("busy", 1'b1, q[`ST_BUSY]);
    wb(1'b1, `OFS_DATA_LO, PAGE[31:0]);
    wb(1'b1, `OFS_DATA_HI, PAGE[63:32]);
    wait_st(`ST_PAGE_REQ);
    chk("page one", PAGE, page);
    chk("bits one", 32'h0000_0040, bits);
    chk("page number", 4'h2, q[11:8]);
    wb(1'b1, `OFS_DATA_LO, ~PAGE[31:0]);
    wb(1'b1, `OFS_DATA_HI, ~PAGE[63:32]);
    wait_st(`ST_UP_DONE);
    chk("page two", ~PAGE, page);
    chk("bits two", 32'h0000_0080, bits);
    chk("setup end", 1'b1, cal_select_n_o);
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_freeze();
    t_power();
    t_cal();
    t_upload();
    t_mid_reset();
    end_of_test();
  end
endmodule // setup_calibration_link_ctrl_test
